/* File: verilog/maf_pkg.sv */
// Package: constants for the module address and I/O front-end
`default_nettype none
package maf_pkg;
    // =====================================================
    // Address selection
    localparam int ADDR_W = 4;
    localparam logic [7:0] REPLY_ADDR_STRAP = 8'hff;
    localparam logic [3:0] ADDR_ALL_LOW = 4'h0;
    // =====================================================
    // Analog input
    localparam int ADC_W = 12;
    localparam logic [11:0] ADC_FULL_SCALE = 12'hfff;
    // =====================================================
    // Timing (clock 10 MHz)
    localparam int CLK_HZ = 10000000;
    localparam int STRAP_SETTLE_US = 10;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_US * (CLK_HZ / 1000000));
    localparam int SETTLE_CNT_W = 8;
    localparam int BAUD_DEFAULT = 9600;
    localparam int BAUD_MAX = 1000000;
    localparam int BAUD_DIV_W = 11;
    // Clocks per bit, rounded down so 9600 baud gives 1041
    localparam int BAUD_DIV_DEFAULT = CLK_HZ / BAUD_DEFAULT;
    localparam int BAUD_DIV_MIN = CLK_HZ / BAUD_MAX;
    // =====================================================
    // Front-end sequencer states
    typedef enum logic [1:0] {
        MAF_SETTLE,
        MAF_CAPTURE,
        MAF_RUN
    } maf_state_t;
endpackage
`default_nettype wire

/* File: verilog/maf_sync3.sv */
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module maf_sync3 #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    // Change counts only once stages two and three agree
    always_comb begin
        out_d = out_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;
endmodule // maf_sync3
`default_nettype wire

/* File: verilog/maf_adc_conv.sv */
// Analog sample conditioning: saturation and digital read
`timescale 1ns/1ps
`default_nettype none
module maf_adc_conv
    import maf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADC_W:0] adc_raw,
    input wire logic adc_raw_valid,
    input wire logic digital_mode,
    input wire logic digital_level,
    output logic [ADC_W-1:0] adc_code,
    output logic adc_code_valid,
    output logic digital_value
);
    logic [ADC_W-1:0] code_q, code_d;
    logic valid_q, valid_d;
    logic dig_q, dig_d;

    // Raw word carries one overrange bit above full scale
    always_comb begin
        code_d = code_q;
        valid_d = 1'b0;
        dig_d = dig_q;
        if (adc_raw_valid && !digital_mode) begin
            valid_d = 1'b1;
            if (adc_raw[ADC_W]) begin
                code_d = ADC_FULL_SCALE;
            end else begin
                code_d = adc_raw[ADC_W-1:0];
            end
        end
        if (digital_mode) begin
            dig_d = digital_level;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            code_q <= '0;
            valid_q <= 1'b0;
            dig_q <= 1'b0;
        end else begin
            code_q <= code_d;
            valid_q <= valid_d;
            dig_q <= dig_d;
        end
    end

    assign adc_code = code_q;
    assign adc_code_valid = valid_q;
    assign digital_value = dig_q;

    AST_ADC_SAT: assert property (@(posedge sys_clk) disable iff (rst)
        (adc_raw_valid && !digital_mode && adc_raw[ADC_W]) |=> (adc_code == ADC_FULL_SCALE && adc_code_valid))
        else $error("Overrange sample not saturated");
    AST_DIG_READ: assert property (@(posedge sys_clk) disable iff (rst)
        digital_mode |=> (digital_value == $past(digital_level)))
        else $error("Digital read does not follow input");
endmodule // maf_adc_conv
`default_nettype wire

/* File: verilog/maf_frontend.sv */
// Top: address selection, limit gating, analog input, factory restore
// Function
// - All straps low: use stored nonvolatile address or node id.
// - Any strap high: address or node id is strap value 1..15.
// - Strap address under native protocol forces reply address 255.
// - Enabled, active left switch blocks negative-direction motion.
// - Enabled, active right switch blocks positive-direction motion.
// - Analog input is 12-bit 0..4095, saturating above range.
// - Analog input may be read as a digital input.
// - Shorted programming pads at power-up restore factory defaults.
// - Defaults apply from next power-up once short removed; here the default rate is forced at once, while the restore request is up.
// - Serial rate defaults to 9600, limited to 1 Mbit/s.
// - CAN interface disabled while USB is connected.
`timescale 1ns/1ps
`default_nettype none
module maf_frontend
    import maf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic address_strap_bit0,
    input wire logic address_strap_bit1,
    input wire logic address_strap_bit2,
    input wire logic address_strap_bit3,
    input wire logic [7:0] stored_address,
    input wire logic [7:0] stored_reply_address,
    input wire logic native_protocol,
    input wire logic limit_left_enable,
    input wire logic limit_right_enable,
    input wire logic limit_left_switch,
    input wire logic limit_right_switch,
    input wire logic move_negative_req,
    input wire logic move_positive_req,
    input wire logic [ADC_W:0] adc_raw,
    input wire logic adc_raw_valid,
    input wire logic analog_digital_mode,
    input wire logic analog_input_channel,
    input wire logic programming_clock_pad,
    input wire logic programming_data_pad,
    input wire logic restore_done,
    input wire logic [BAUD_DIV_W-1:0] baud_div_config,
    input wire logic baud_config_valid,
    input wire logic usb_present,
    output logic [7:0] module_address,
    output logic [7:0] reply_address,
    output logic address_from_straps,
    output logic address_valid,
    output logic move_negative_allow,
    output logic move_positive_allow,
    output logic [ADC_W-1:0] adc_code,
    output logic adc_code_valid,
    output logic analog_digital_value,
    output logic factory_restore_req,
    output logic [BAUD_DIV_W-1:0] baud_div,
    output logic can_enable
);
    // =====================================================
    // Input synchronisers for pins
    logic [3:0] strap_s;
    logic lim_l_s, lim_r_s, ain_s, pclk_s, pdat_s, usb_s;

    maf_sync3 #(.W(10)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({address_strap_bit3, address_strap_bit2, address_strap_bit1, address_strap_bit0,
                   limit_left_switch, limit_right_switch, analog_input_channel,
                   programming_clock_pad, programming_data_pad, usb_present}),
        .sync_out({strap_s, lim_l_s, lim_r_s, ain_s, pclk_s, pdat_s, usb_s})
    );

    // =====================================================
    // Power-up sequencer: settle, capture straps and pads once
    maf_state_t state_q, state_d;
    logic [SETTLE_CNT_W-1:0] cnt_q, cnt_d;
    logic [7:0] addr_q, addr_d;
    logic [7:0] reply_q, reply_d;
    logic strap_q, strap_d;
    logic valid_q, valid_d;
    logic restore_q, restore_d;

    localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(STRAP_SETTLE_CYC - 1);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        reply_d = reply_q;
        strap_d = strap_q;
        valid_d = valid_q;
        restore_d = restore_q;
        unique case (state_q)
            MAF_SETTLE: begin
                // Wait for the synchroniser and pull-ups to settle
                if (cnt_q == SETTLE_LAST) begin
                    state_d = MAF_CAPTURE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            MAF_CAPTURE: begin
                if (strap_s == ADDR_ALL_LOW) begin
                    addr_d = stored_address;
                    reply_d = stored_reply_address;
                    strap_d = 1'b0;
                end else begin
                    addr_d = {4'h0, strap_s};
                    strap_d = 1'b1;
                    reply_d = native_protocol ? REPLY_ADDR_STRAP : stored_reply_address;
                end
                // Shorted pads read equal-high under the pad pull-ups
                restore_d = pclk_s && pdat_s;
                valid_d = 1'b1;
                state_d = MAF_RUN;
            end
            MAF_RUN: begin
                // Straps no longer looked at until next reset
                if (restore_done) begin
                    restore_d = 1'b0;
                end
            end
            default: begin
                state_d = MAF_SETTLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= MAF_SETTLE;
            cnt_q <= '0;
            addr_q <= 8'h00;
            reply_q <= 8'h00;
            strap_q <= 1'b0;
            valid_q <= 1'b0;
            restore_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            reply_q <= reply_d;
            strap_q <= strap_d;
            valid_q <= valid_d;
            restore_q <= restore_d;
        end
    end

    // =====================================================
    // Limit gating, baud select, CAN enable
    logic neg_q, neg_d, pos_q, pos_d;
    logic [BAUD_DIV_W-1:0] baud_q, baud_d;
    logic can_q, can_d;

    localparam logic [BAUD_DIV_W-1:0] DIV_DEFAULT = BAUD_DIV_W'(BAUD_DIV_DEFAULT);
    localparam logic [BAUD_DIV_W-1:0] DIV_MIN = BAUD_DIV_W'(BAUD_DIV_MIN);

    always_comb begin
        neg_d = move_negative_req && !(limit_left_enable && lim_l_s);
        pos_d = move_positive_req && !(limit_right_enable && lim_r_s);
        baud_d = baud_q;
        // Faster than the transceiver limit clamps to it
        if (restore_q) begin
            baud_d = DIV_DEFAULT;
        end else if (baud_config_valid) begin
            baud_d = (baud_div_config < DIV_MIN) ? DIV_MIN : baud_div_config;
        end
        can_d = !usb_s;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            neg_q <= 1'b0;
            pos_q <= 1'b0;
            baud_q <= DIV_DEFAULT;
            can_q <= 1'b0;
        end else begin
            neg_q <= neg_d;
            pos_q <= pos_d;
            baud_q <= baud_d;
            can_q <= can_d;
        end
    end

    // =====================================================
    // Analog input
    maf_adc_conv u_adc (
        .sys_clk(sys_clk),
        .rst(rst),
        .adc_raw(adc_raw),
        .adc_raw_valid(adc_raw_valid),
        .digital_mode(analog_digital_mode),
        .digital_level(ain_s),
        .adc_code(adc_code),
        .adc_code_valid(adc_code_valid),
        .digital_value(analog_digital_value)
    );

    assign module_address = addr_q;
    assign reply_address = reply_q;
    assign address_from_straps = strap_q;
    assign address_valid = valid_q;
    assign move_negative_allow = neg_q;
    assign move_positive_allow = pos_q;
    assign factory_restore_req = restore_q;
    assign baud_div = baud_q;
    assign can_enable = can_q;

    // =====================================================
    // Assertions
    sequence seq_capture;
        state_q == MAF_CAPTURE;
    endsequence

    sequence seq_straps_low;
        seq_capture ##0 (strap_s == ADDR_ALL_LOW);
    endsequence

    sequence seq_straps_high;
        seq_capture ##0 (strap_s != ADDR_ALL_LOW);
    endsequence

    sequence seq_pads_shorted;
        seq_capture ##0 (pclk_s && pdat_s);
    endsequence

    // =====================================================
    // Address and reply address capture
    AST_STORED_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
        seq_straps_low |=> (module_address == $past(stored_address) && !address_from_straps))
        else $error("Stored address not used with straps low");
    AST_REPLY_STORED: assert property (@(posedge sys_clk) disable iff (rst)
        seq_straps_low |=> (reply_address == $past(stored_reply_address)))
        else $error("Stored reply address not used with straps low");
    AST_STRAP_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
        seq_straps_high
            |=> (module_address == {4'h0, $past(strap_s)} && address_from_straps))
        else $error("Strap address not taken");
    AST_STRAP_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
        (address_valid && address_from_straps) |-> (module_address >= 8'h01 && module_address <= 8'h0f))
        else $error("Strap address outside 1 to 15");
    AST_REPLY_255: assert property (@(posedge sys_clk) disable iff (rst)
        (seq_straps_high ##0 native_protocol) |=> (reply_address == REPLY_ADDR_STRAP))
        else $error("Reply address not 255 under strap addressing");
    AST_REPLY_OTHER: assert property (@(posedge sys_clk) disable iff (rst)
        (seq_straps_high ##0 !native_protocol) |=> (reply_address == $past(stored_reply_address)))
        else $error("Reply address forced outside native protocol");

    // =====================================================
    // Limit gating: blocked only while enabled and active
    AST_LEFT_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
        (limit_left_enable && lim_l_s) |=> !move_negative_allow)
        else $error("Negative motion not blocked by left switch");
    AST_LEFT_PASS: assert property (@(posedge sys_clk) disable iff (rst)
        (move_negative_req && !(limit_left_enable && lim_l_s)) |=> move_negative_allow)
        else $error("Negative motion blocked without active left switch");
    AST_RIGHT_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
        (limit_right_enable && lim_r_s) |=> !move_positive_allow)
        else $error("Positive motion not blocked by right switch");
    AST_RIGHT_PASS: assert property (@(posedge sys_clk) disable iff (rst)
        (move_positive_req && !(limit_right_enable && lim_r_s)) |=> move_positive_allow)
        else $error("Positive motion blocked without active right switch");
    AST_LIMIT_IGNORED: assert property (@(posedge sys_clk) disable iff (rst)
        (!limit_left_enable && !limit_right_enable && move_negative_req && move_positive_req)
            |=> (move_negative_allow && move_positive_allow))
        else $error("Disabled switch restricted motion");

    // =====================================================
    // Factory restore
    AST_RESTORE: assert property (@(posedge sys_clk) disable iff (rst)
        seq_pads_shorted |=> factory_restore_req ##1 (baud_div == DIV_DEFAULT))
        else $error("Shorted pads did not request restore");
    AST_NO_RESTORE: assert property (@(posedge sys_clk) disable iff (rst)
        (seq_capture ##0 !(pclk_s && pdat_s)) |=> !factory_restore_req)
        else $error("Restore requested without shorted pads");
    AST_RESTORE_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == MAF_RUN && restore_done) |=> !factory_restore_req)
        else $error("Restore request outlived the store rewrite");

    // =====================================================
    // Capture once per reset
    AST_ADDR_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == MAF_RUN) |=> ($stable(module_address) && $stable(address_from_straps)))
        else $error("Address changed after capture");
    AST_VALID_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        address_valid |=> address_valid)
        else $error("Address valid dropped before reset");
    AST_SETTLE_TIME: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == MAF_SETTLE && cnt_q == SETTLE_LAST) |=> seq_capture)
        else $error("Capture did not follow the settle count");

    // =====================================================
    // Serial rate and CAN enable
    AST_BAUD_LIMIT: assert property (@(posedge sys_clk) disable iff (rst)
        address_valid |-> (baud_div >= DIV_MIN))
        else $error("Serial rate above hardware limit");
    AST_BAUD_RESTORE: assert property (@(posedge sys_clk) disable iff (rst)
        factory_restore_req |=> (baud_div == DIV_DEFAULT))
        else $error("Default rate not held during restore");
    AST_BAUD_CFG: assert property (@(posedge sys_clk) disable iff (rst)
        (!factory_restore_req && baud_config_valid && baud_div_config >= DIV_MIN)
            |=> (baud_div == $past(baud_div_config)))
        else $error("Configured rate not taken");
    AST_CAN_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        usb_s |=> !can_enable)
        else $error("CAN enabled with USB present");
    AST_CAN_ON: assert property (@(posedge sys_clk) disable iff (rst)
        !usb_s |=> can_enable)
        else $error("CAN disabled without USB present");
endmodule // maf_frontend
`default_nettype wire

/* File: verif/maf_host_model.sv */
// Host-side partner: stored settings and the settings-store restore handshake
`timescale 1ns/1ps
`default_nettype none
module maf_host_model #(
    parameter logic [7:0] STORED_ADDR = 8'h23,
    parameter logic [7:0] STORED_REPLY = 8'h02,
    parameter int RESTORE_CYC = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic factory_restore_req,
    input wire logic native_sel,
    output logic restore_done,
    output logic [7:0] stored_address,
    output logic [7:0] stored_reply_address,
    output logic native_protocol
);
    logic [7:0] busy_q;
    assign stored_address = STORED_ADDR;
    assign stored_reply_address = STORED_REPLY;
    assign native_protocol = native_sel;
    // Store takes a while to rewrite; one done pulse per request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_q <= 8'h00;
            restore_done <= 1'b0;
        end else begin
            busy_q <= factory_restore_req ? busy_q + 8'h01 : 8'h00;
            restore_done <= factory_restore_req && (busy_q == 8'(RESTORE_CYC - 1));
        end
    end
endmodule // maf_host_model
`default_nettype wire

/* File: verif/module_address_and_io_frontend_test.sv */
// Testbench of the address and I/O front-end
`timescale 1ns/1ps
`default_nettype none
module module_address_and_io_frontend_test;
    import maf_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] straps = 4'h0;
    logic [7:0] st_addr, st_reply, mod_addr, rep_addr;
    logic native_sel = 1'b1;
    logic native, lle = 1'b0, lre = 1'b0, lls = 1'b0, lrs = 1'b0, mneg = 1'b0, mpos = 1'b0;
    logic [ADC_W:0] adc_raw = '0;
    logic adc_vld = 1'b0, dmode = 1'b0, ain = 1'b0, pclk = 1'b0, pdat = 1'b0, rdone;
    logic [BAUD_DIV_W-1:0] bcfg = '0, bdiv;
    logic bvld = 1'b0, usb = 1'b0;
    logic from_straps, addr_vld, neg_ok, pos_ok, code_vld, dval, rreq, can_en;
    logic [ADC_W-1:0] code;
    int mismatches = 0;
    int total_checks = 0;
    always #50 sys_clk = ~sys_clk;
    maf_host_model host (.sys_clk(sys_clk), .rst(rst), .factory_restore_req(rreq), .restore_done(rdone),
        .native_sel(native_sel), .stored_address(st_addr), .stored_reply_address(st_reply),
        .native_protocol(native));
    maf_frontend uut (.sys_clk(sys_clk), .rst(rst), .address_strap_bit0(straps[0]),
        .address_strap_bit1(straps[1]), .address_strap_bit2(straps[2]), .address_strap_bit3(straps[3]),
        .stored_address(st_addr), .stored_reply_address(st_reply), .native_protocol(native),
        .limit_left_enable(lle), .limit_right_enable(lre), .limit_left_switch(lls),
        .limit_right_switch(lrs), .move_negative_req(mneg), .move_positive_req(mpos),
        .adc_raw(adc_raw), .adc_raw_valid(adc_vld), .analog_digital_mode(dmode),
        .analog_input_channel(ain), .programming_clock_pad(pclk), .programming_data_pad(pdat),
        .restore_done(rdone), .baud_div_config(bcfg), .baud_config_valid(bvld), .usb_present(usb),
        .module_address(mod_addr), .reply_address(rep_addr), .address_from_straps(from_straps),
        .address_valid(addr_vld), .move_negative_allow(neg_ok), .move_positive_allow(pos_ok),
        .adc_code(code), .adc_code_valid(code_vld), .analog_digital_value(dval),
        .factory_restore_req(rreq), .baud_div(bdiv), .can_enable(can_en));
    // =====================================================
    // Shared helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Pins must settle before release so the capture sees them
    task automatic do_reset();
        rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        for (int i = 0; i < 200 && addr_vld !== 1'b1; i++) @(negedge sys_clk);
        check(addr_vld, 1'b1);
    endtask
    task automatic cfg_baud(input logic [10:0] v);
        bcfg = v;
        bvld = 1'b1;
        @(negedge sys_clk);
        bvld = 1'b0;
        @(negedge sys_clk);
    endtask
    // =====================================================
    // Scenarios
    task automatic t_stored_addr();
        straps = 4'h0;
        do_reset();
        check(mod_addr, 8'h23);
        check(rep_addr, 8'h02);
        check(from_straps, 1'b0);
        check(bdiv, 11'h411);
        $display("test stored address done");
    endtask
    task automatic t_strap_addr();
        straps = 4'ha;
        do_reset();
        check(mod_addr, 8'h0a);
        check(rep_addr, 8'hff);
        check(from_straps, 1'b1);
        straps = 4'h5;
        repeat (10) @(negedge sys_clk);
        check(mod_addr, 8'h0a);
        straps = 4'h8;
        native_sel = 1'b0;
        do_reset();
        check(mod_addr, 8'h08);
        check(rep_addr, 8'h02);
        native_sel = 1'b1;
        $display("test strap address done");
    endtask
    task automatic t_limits();
        mneg = 1'b1;
        mpos = 1'b1;
        lls = 1'b1;
        lrs = 1'b1;
        repeat (8) @(negedge sys_clk);
        check({neg_ok, pos_ok}, 2'b11);
        lle = 1'b1;
        @(negedge sys_clk);
        @(negedge sys_clk);
        check({neg_ok, pos_ok}, 2'b01);
        lre = 1'b1;
        lls = 1'b0;
        repeat (8) @(negedge sys_clk);
        check({neg_ok, pos_ok}, 2'b10);
        lrs = 1'b0;
        repeat (8) @(negedge sys_clk);
        check({neg_ok, pos_ok}, 2'b11);
        mneg = 1'b0;
        @(negedge sys_clk);
        @(negedge sys_clk);
        check(neg_ok, 1'b0);
        $display("test limits done");
    endtask
    task automatic t_adc();
        logic [12:0] raw [3] = '{13'h0123, 13'h0fff, 13'h1005};
        logic [11:0] exp [3] = '{12'h123, 12'hfff, 12'hfff};
        for (int i = 0; i < 3; i++) begin
            adc_raw = raw[i];
            adc_vld = 1'b1;
            @(negedge sys_clk);
            check(code_vld, 1'b1);
            check(code, exp[i]);
            adc_vld = 1'b0;
            @(negedge sys_clk);
            check(code_vld, 1'b0);
        end
        dmode = 1'b1;
        ain = 1'b1;
        adc_raw = 13'h0001;
        adc_vld = 1'b1;
        @(negedge sys_clk);
        adc_vld = 1'b0;
        repeat (7) @(negedge sys_clk);
        check(dval, 1'b1);
        check(code, 12'hfff);
        ain = 1'b0;
        repeat (8) @(negedge sys_clk);
        check(dval, 1'b0);
        dmode = 1'b0;
        $display("test analog done");
    endtask
    task automatic t_baud_usb();
        cfg_baud(11'h005);
        check(bdiv, 11'h00a);
        cfg_baud(11'h064);
        check(bdiv, 11'h064);
        usb = 1'b1;
        repeat (8) @(negedge sys_clk);
        check(can_en, 1'b0);
        usb = 1'b0;
        repeat (8) @(negedge sys_clk);
        check(can_en, 1'b1);
        $display("test baud and usb done");
    endtask
    task automatic t_restore();
        pclk = 1'b1;
        pdat = 1'b1;
        do_reset();
        check(rreq, 1'b1);
        cfg_baud(11'h064);
        check(bdiv, 11'h411);
        for (int i = 0; i < 100 && rreq !== 1'b0; i++) @(negedge sys_clk);
        check(rreq, 1'b0);
        pclk = 1'b0;
        pdat = 1'b0;
        do_reset();
        check(rreq, 1'b0);
        check(bdiv, 11'h411);
        $display("test factory restore done");
    endtask
    // =====================================================
    // Main sequence and watchdog
    initial begin
        t_stored_addr();
        t_strap_addr();
        t_limits();
        t_adc();
        t_baud_usb();
        t_restore();
        results();
    end
    // Whole run is under 1500 cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        results();
    end
endmodule // module_address_and_io_frontend_test
`default_nettype wire
